// file: src/rrx_pkg.sv
// constants for the register reference decode and execute block
package rrx_pkg;
  // ---------------------------------------------------------------
  // instruction word fields
  // ---------------------------------------------------------------
  localparam int unsigned RRX_W = 16;
  localparam logic [3:0] RRX_CLASS_RR = 4'h0;
  localparam int unsigned RRX_BIT_ACC = 11;
  localparam int unsigned RRX_BIT_GROUP = 10;
  localparam int unsigned RRX_BIT_EN1 = 9;
  localparam int unsigned RRX_BIT_CLE = 5;
  localparam int unsigned RRX_BIT_EN2 = 4;
  localparam int unsigned RRX_BIT_T_LSB = 3;
  localparam int unsigned RRX_BIT_T_EXT = 5;
  localparam int unsigned RRX_BIT_T_SIGN = 4;
  localparam int unsigned RRX_BIT_INC = 2;
  localparam int unsigned RRX_BIT_T_ZERO = 1;
  localparam int unsigned RRX_BIT_REV = 0;

  // shift/rotate codes, first position bits 8:6, second bits 2:0
  typedef enum logic [2:0] {
    RRX_SH_ASL = 3'h0,
    RRX_SH_ASR = 3'h1,
    RRX_SH_ROL = 3'h2,
    RRX_SH_ROR = 3'h3,
    RRX_SH_SLC = 3'h4,
    RRX_SH_ERR = 3'h5,
    RRX_SH_ERL = 3'h6,
    RRX_SH_RL4 = 3'h7
  } rrx_shift_e;

  // accumulator alter codes (bits 9:8) and extend alter codes (bits 7:6)
  localparam logic [1:0] RRX_ALT_NONE = 2'h0;
  localparam logic [1:0] RRX_ALT_CLR = 2'h1;
  localparam logic [1:0] RRX_ALT_CMP = 2'h2;
  localparam logic [1:0] RRX_ALT_SET = 2'h3;

  localparam logic [15:0] RRX_ZERO = 16'h0000;
  localparam logic [15:0] RRX_ONES = 16'hFFFF;
  localparam logic [15:0] RRX_MAX_POS = 16'h7FFF;

  // ---------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ---------------------------------------------------------------
  localparam int unsigned RRX_AW = 4;
  localparam logic [3:0] RRX_REG_ACC_A = 4'h0;
  localparam logic [3:0] RRX_REG_ACC_B = 4'h4;
  localparam logic [3:0] RRX_REG_FLAGS = 4'h8;
  localparam logic [3:0] RRX_REG_CTRL = 4'hC;
  localparam int unsigned RRX_FLG_E = 0;
  localparam int unsigned RRX_FLG_O = 1;
  localparam int unsigned RRX_FLG_SKIP = 2;
  localparam int unsigned RRX_CTL_EN = 0;
  localparam logic RRX_CTL_EN_RST = 1'b1;
  localparam logic [1:0] RRX_RESP_OKAY = 2'h0;
  localparam logic [1:0] RRX_RESP_SLVERR = 2'h2;
  localparam logic [14:0] RRX_PC_STEP = 15'h0001;
  localparam logic [14:0] RRX_PC_SKIP = 15'h0002;
endpackage : rrx_pkg

// file: src/rrx_core.sv
// register reference instruction decode and execute with an AXI4-Lite register port
// Functional notes
// - bit 10 clear selects shift/rotate group, set selects alter/skip group
// - one accumulator per word; one choice per multiple-choice column
// - packed operations run left to right, each sees earlier results except the extend test, which sees extend before it is altered
// - first shift enabled by bit 9, second shift by bit 4
// - disabled rotate-through-extend still updates extend, accumulator untouched
// - all-zero word is a no-operation, no state change, no skip
// - arithmetic left shift keeps sign, drops bit 14, zero into bit 0
// - arithmetic right shift keeps sign, copies sign into bit 14
// - sign-clearing left shift shifts left then clears bit 15
// - four-place left rotate moves bits 15..12 into 3..0
// - single rotates move all 16 bits, end bit wraps around
// - extend rotates pass extend into end bit and end bit into extend
// - clear extend gives 0, clear-complement gives 1, complement inverts
// - lsb skip test fires when bit 0 of accumulator is 0
// - clear gives zero, clear-complement all ones, complement inverts bits
// - increment adds one; sets overflow at 077777, extend at 177777
// - several skip tests without reverse sense skip if any is true
// - reverse sense flips tests; reverse sense alone skips always
// - reverse sense with sign and lsb tests needs both bits 1
// - extend-zero skip test fires when extend is 0
// - sign skip test fires when bit 15 of accumulator is 0
// - zero skip test fires when accumulator is all zero
// - taken skip advances program counter by two instead of one
`timescale 1ns/1ps
module rrx_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [rrx_pkg::RRX_W-1:0] instr_word,
  input wire logic [14:0] pc_in,
  output logic instr_ready_q,
  output logic done_q,
  output logic skip_q,
  output logic [14:0] pc_next_q,
  output logic [rrx_pkg::RRX_W-1:0] acc_a_q,
  output logic [rrx_pkg::RRX_W-1:0] acc_b_q,
  output logic extend_q,
  output logic overflow_q,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rrx_pkg::*;

  // ---------------------------------------------------------------
  // shift/rotate unit, returns {extend, value}
  // ---------------------------------------------------------------
  function automatic logic [16:0] rrx_shift(input logic [2:0] op, input logic en,
                                            input logic [15:0] v, input logic e);
    logic [15:0] r;
    logic ne;
    r = v;
    ne = e;
    unique case (rrx_shift_e'(op))
      RRX_SH_ASL: r = {v[15], v[13:0], 1'b0};
      RRX_SH_ASR: r = {v[15], v[15], v[14:1]};
      RRX_SH_ROL: r = {v[14:0], v[15]};
      RRX_SH_ROR: r = {v[0], v[15:1]};
      RRX_SH_SLC: r = {1'b0, v[13:0], 1'b0};
      RRX_SH_ERR: begin
        r = {e, v[15:1]};
        ne = v[0];
      end
      RRX_SH_ERL: begin
        r = {v[14:0], e};
        ne = v[15];
      end
      RRX_SH_RL4: r = {v[11:0], v[15:12]};
    endcase
    // extend moves even when the shift itself is disabled
    return {ne, en ? r : v};
  endfunction : rrx_shift

  function automatic logic rrx_is_zero(input logic [15:0] v);
    return v == RRX_ZERO;
  endfunction : rrx_is_zero

  // ---------------------------------------------------------------
  // execute: next state for the word at instr_word
  // ---------------------------------------------------------------
  logic ctl_en_q;
  logic fire;
  logic use_b;
  logic is_rr;
  logic [15:0] acc_in;
  logic [15:0] acc_nx;
  logic e_nx;
  logic o_nx;
  logic skip_nx;

  assign fire = instr_valid & instr_ready_q & ctl_en_q;
  assign use_b = instr_word[RRX_BIT_ACC];
  assign is_rr = instr_word[15:12] == RRX_CLASS_RR;
  assign acc_in = use_b ? acc_b_q : acc_a_q;

  always_comb begin
    logic [16:0] s1;
    logic [16:0] s2;
    logic [15:0] v1;
    logic e1;
    logic [15:0] v2;
    logic t_ext;
    logic t_sign;
    logic t_lsb;
    logic t_zero;
    logic pair;
    s1 = '0;
    s2 = '0;
    v1 = acc_in;
    e1 = extend_q;
    v2 = acc_in;
    t_ext = instr_word[RRX_BIT_T_EXT];
    t_sign = instr_word[RRX_BIT_T_SIGN];
    t_lsb = instr_word[RRX_BIT_T_LSB];
    t_zero = instr_word[RRX_BIT_T_ZERO];
    pair = 1'b0;
    acc_nx = acc_in;
    e_nx = extend_q;
    o_nx = overflow_q;
    skip_nx = 1'b0;
    if (!instr_word[RRX_BIT_GROUP]) begin
      // shift, clear extend, lsb test, shift: in that order
      s1 = rrx_shift(instr_word[8:6], instr_word[RRX_BIT_EN1], acc_in, extend_q);
      e1 = instr_word[RRX_BIT_CLE] ? 1'b0 : s1[16];
      skip_nx = t_lsb & ~s1[0];
      s2 = rrx_shift(instr_word[2:0], instr_word[RRX_BIT_EN2], s1[15:0], e1);
      acc_nx = s2[15:0];
      e_nx = s2[16];
    end else begin
      unique case (instr_word[9:8])
        RRX_ALT_NONE: v1 = acc_in;
        RRX_ALT_CLR: v1 = RRX_ZERO;
        RRX_ALT_CMP: v1 = ~acc_in;
        RRX_ALT_SET: v1 = RRX_ONES;
      endcase
      // extend test looks at extend before it is altered
      unique case (instr_word[7:6])
        RRX_ALT_NONE: e1 = extend_q;
        RRX_ALT_CLR: e1 = 1'b0;
        RRX_ALT_CMP: e1 = ~extend_q;
        RRX_ALT_SET: e1 = 1'b1;
      endcase
      v2 = v1;
      e_nx = e1;
      if (instr_word[RRX_BIT_INC]) begin
        v2 = v1 + 16'h0001;
        if (v1 == RRX_MAX_POS) o_nx = 1'b1;
        if (v1 == RRX_ONES) e_nx = 1'b1;
      end
      acc_nx = v2;
      if (!instr_word[RRX_BIT_REV]) begin
        skip_nx = (t_ext & ~extend_q) | (t_sign & ~v1[15]) |
                  (t_lsb & ~v1[0]) | (t_zero & rrx_is_zero(v2));
      end else begin
        pair = (t_sign & t_lsb) ? (v1[15] & v1[0]) :
               ((t_sign & v1[15]) | (t_lsb & v1[0]));
        skip_nx = ~(t_ext | t_sign | t_lsb | t_zero) | (t_ext & extend_q) | pair |
                  (t_zero & ~rrx_is_zero(v2));
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic wr_go;
  logic wr_hs;
  logic rd_go;
  logic [3:0] wa;
  logic [3:0] ra;
  logic wr_hit;
  logic rd_hit;

  assign wa = s_axi_awaddr[RRX_AW-1:0];
  assign ra = s_axi_araddr[RRX_AW-1:0];
  // a write is taken only in a cycle where no instruction may execute
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign wr_hs = s_axi_awready;
  assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  function automatic logic rrx_mapped(input logic [31:0] addr);
    return addr[31:RRX_AW] == '0 && addr[1:0] == 2'h0;
  endfunction : rrx_mapped

  assign wr_hit = rrx_mapped(s_axi_awaddr);
  assign rd_hit = rrx_mapped(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      instr_ready_q <= 1'b1;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      instr_ready_q <= ~wr_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RRX_RESP_OKAY;
    end else if (wr_hs) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RRX_RESP_OKAY : RRX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= rd_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RRX_RESP_OKAY;
    end else if (s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_hit ? RRX_RESP_OKAY : RRX_RESP_SLVERR;
      s_axi_rdata <= '0;
      if (rd_hit) begin
        unique case (ra)
          RRX_REG_ACC_A: s_axi_rdata <= {16'h0000, acc_a_q};
          RRX_REG_ACC_B: s_axi_rdata <= {16'h0000, acc_b_q};
          RRX_REG_FLAGS: s_axi_rdata <= {29'h00000000, skip_q, overflow_q, extend_q};
          RRX_REG_CTRL: s_axi_rdata <= {31'h00000000, ctl_en_q};
          default: s_axi_rdata <= '0;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // architectural state: instruction execution or register write
  // ---------------------------------------------------------------
  logic [15:0] wdat;
  assign wdat = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                 s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_a_q <= RRX_ZERO;
      acc_b_q <= RRX_ZERO;
      extend_q <= 1'b0;
      overflow_q <= 1'b0;
    end else if (fire && is_rr) begin
      if (use_b) acc_b_q <= acc_nx;
      else acc_a_q <= acc_nx;
      extend_q <= e_nx;
      overflow_q <= o_nx;
    end else if (wr_hs && wr_hit) begin
      // partial strobes keep the other byte lane
      if (wa == RRX_REG_ACC_A) begin
        acc_a_q <= (acc_a_q & ~{{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}) | wdat;
      end
      if (wa == RRX_REG_ACC_B) begin
        acc_b_q <= (acc_b_q & ~{{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}) | wdat;
      end
      if (wa == RRX_REG_FLAGS && s_axi_wstrb[0]) begin
        extend_q <= s_axi_wdata[RRX_FLG_E];
        overflow_q <= s_axi_wdata[RRX_FLG_O];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_en_q <= RRX_CTL_EN_RST;
    end else if (wr_hs && wr_hit && wa == RRX_REG_CTRL && s_axi_wstrb[0]) begin
      ctl_en_q <= s_axi_wdata[RRX_CTL_EN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
      pc_next_q <= '0;
    end else begin
      done_q <= fire;
      if (fire) begin
        skip_q <= is_rr & skip_nx;
        pc_next_q <= pc_in + ((is_rr & skip_nx) ? RRX_PC_SKIP : RRX_PC_STEP);
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic alt_a;
  assign alt_a = fire && is_rr && instr_word[RRX_BIT_GROUP] && !use_b;

  a_nop_quiet: assert property (fire && instr_word == 16'h0000 |=>
      $stable(acc_a_q) && $stable(acc_b_q) && $stable(extend_q) && !skip_q)
    else $error("nop changed state or skipped");
  a_pc_step: assert property (fire |=>
      pc_next_q == $past(pc_in) + (skip_q ? RRX_PC_SKIP : RRX_PC_STEP))
    else $error("pc advance wrong");
  a_acc_other: assert property (fire && use_b |=> $stable(acc_a_q))
    else $error("A changed by a B word");
  a_clear_acc: assert property (alt_a && instr_word[9:0] == 10'h100 |=>
      acc_a_q == RRX_ZERO)
    else $error("clear did not give zero");
  a_set_ones: assert property (alt_a && instr_word[9:0] == 10'h300 |=>
      acc_a_q == RRX_ONES && !skip_q)
    else $error("clear-complement did not give ones");
  a_ext_set: assert property (fire && is_rr && instr_word[RRX_BIT_GROUP] &&
      instr_word[7:6] == RRX_ALT_SET |=> extend_q)
    else $error("extend not set");
  a_inc_ovf: assert property (alt_a && instr_word[9:0] == 10'h004 &&
      acc_a_q == RRX_MAX_POS |=> overflow_q && acc_a_q == 16'h8000)
    else $error("increment overflow wrong");
  a_rev_alone: assert property (fire && is_rr && instr_word[RRX_BIT_GROUP] &&
      instr_word[5:0] == 6'h01 |=> skip_q && pc_next_q == $past(pc_in) + RRX_PC_SKIP)
    else $error("reverse sense alone did not skip");
  a_zero_skip: assert property (alt_a && instr_word[9:0] == 10'h002 &&
      acc_a_q == RRX_ZERO |=> skip_q)
    else $error("zero test did not skip");
  a_rot_four: assert property (fire && is_rr && !instr_word[RRX_BIT_GROUP] && !use_b &&
      instr_word[9:0] == 10'h3C0 |=> {acc_a_q[3:0], acc_a_q[15:4]} == $past(acc_a_q))
    else $error("four-place rotate wrong");
  a_dis_erot: assert property (fire && is_rr && instr_word[10:0] == 11'h005 &&
      !use_b |=> $stable(acc_a_q) && extend_q == acc_a_q[0])
    else $error("disabled extend rotate wrong");

  c_skip_taken: cover property (fire && is_rr ##1 skip_q);
  c_shift_two: cover property (fire && is_rr && !instr_word[RRX_BIT_GROUP] &&
      instr_word[RRX_BIT_EN1] && instr_word[RRX_BIT_EN2]);
  c_write_then_exec: cover property (wr_hs ##1 fire);
endmodule : rrx_core

// file: tb/rrx_fetch_model.sv
// fetch and program counter sequencing model that feeds the decode block
`timescale 1ns/1ps
module rrx_fetch_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_ready_q,
  input wire logic done_q,
  input wire logic [14:0] pc_next_q,
  output logic instr_valid,
  output logic [15:0] instr_word,
  output logic [14:0] pc_in
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    pc_in = 15'h0000;
  end

  // next fetch address follows the block's own sequencing
  always @(posedge aclk) begin
    if (!aresetn) pc_in <= 15'h0100;
    else if (done_q) pc_in <= pc_next_q;
  end

  // each idle cycle inverts the word, so the stale value differs from the last live one only after an odd number of them
  task automatic quiet();
    instr_valid <= 1'b0;
    instr_word <= ~instr_word;
    @(posedge aclk);
  endtask : quiet

  // gap idle cycles first, then the word is held until instr_ready_q is seen high, even while execute enable is off
  task automatic issue(input logic [15:0] w, input int gap, output logic [14:0] pc);
    repeat (gap) quiet();
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge aclk); while (instr_ready_q !== 1'b1);
    pc = pc_in;
  endtask : issue
endmodule : rrx_fetch_model

// file: tb/tb_top.sv
// self-checking bench for the register reference decode and execute block
`timescale 1ns/1ps
`define CHK(g, x) begin \
  checks_done++; \
  if ((g) !== (x)) begin \
    n_mismatch++; \
    $display("BAD %0t got %h want %h", $time, (g), (x)); \
  end \
end
module tb_top;
  import rrx_pkg::*;
  logic aclk, aresetn, instr_valid, instr_ready_q, done_q, skip_q, extend_q, overflow_q;
  logic [15:0] instr_word, acc_a_q, acc_b_q;
  logic [14:0] pc_in, pc_next_q, pc_hold;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] exp_a, exp_b;
  logic exp_e, exp_o, exp_skip;
  logic [49:0] expq[$];
  logic [49:0] q;
  logic [15:0] corner[8] = '{16'h7FFF, 16'hFFFF, 16'h8001, 16'h0000,
                             16'h8000, 16'h0001, 16'h5A3C, 16'hC3A5};
  int n_mismatch, checks_done, cyc, seed, i;

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  rrx_core dut_u (
    .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr_word(instr_word),
    .pc_in(pc_in), .instr_ready_q(instr_ready_q), .done_q(done_q), .skip_q(skip_q),
    .pc_next_q(pc_next_q), .acc_a_q(acc_a_q), .acc_b_q(acc_b_q), .extend_q(extend_q),
    .overflow_q(overflow_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  rrx_fetch_model fetch_u (
    .aclk(aclk), .aresetn(aresetn), .instr_ready_q(instr_ready_q), .done_q(done_q),
    .pc_next_q(pc_next_q), .instr_valid(instr_valid), .instr_word(instr_word),
    .pc_in(pc_in)
  );

  // ---------------------------------------------------------------
  // reference behaviour
  // ---------------------------------------------------------------
  function automatic logic [16:0] ref_shift(logic [2:0] op, logic en, logic e,
                                            logic [15:0] v);
    logic [15:0] r;
    case (op)
      3'h0: r = {v[15], v[13:0], 1'b0};
      3'h1: r = {v[15], v[15:1]};
      3'h2: r = {v[14:0], v[15]};
      3'h3: r = {v[0], v[15:1]};
      3'h4: r = {1'b0, v[13:0], 1'b0};
      3'h5: r = {e, v[15:1]};
      3'h6: r = {v[14:0], e};
      default: r = {v[11:0], v[15:12]};
    endcase
    // extend rotates move the extend bit even when the position is disabled
    if (op == 3'h5) e = v[0];
    if (op == 3'h6) e = v[15];
    return {e, en ? r : v};
  endfunction : ref_shift

  function automatic logic [34:0] ref_exec(logic [15:0] w, logic [15:0] a, logic [15:0] b,
                                           logic e, logic o);
    logic [15:0] v;
    logic e0, sk, rv, ts, tl;
    v = w[11] ? b : a;
    e0 = e;
    rv = w[0];
    ts = w[4];
    tl = w[3];
    if (w[15:12] != 4'h0) return {1'b0, o, e, b, a};
    if (!w[10]) begin
      {e, v} = ref_shift(w[8:6], w[9], e, v);
      if (w[5]) e = 1'b0;
      sk = tl & ~v[0];
      {e, v} = ref_shift(w[2:0], w[4], e, v);
    end else begin
      v = w[9] ? (w[8] ? 16'hFFFF : ~v) : (w[8] ? 16'h0000 : v);
      e = w[7] ? (w[6] | ~e) : (~w[6] & e);
      sk = (w[5] & (e0 ^ ~rv)) | (ts & tl & rv & v[15] & v[0]);
      if (!(ts & tl & rv)) sk = sk | (ts & (v[15] ^ ~rv)) | (tl & (v[0] ^ ~rv));
      if (w[2]) begin
        if (v == 16'h7FFF) o = 1'b1;
        if (v == 16'hFFFF) e = 1'b1;
        v = v + 16'h0001;
      end
      sk = sk | (w[1] & ((v == 16'h0000) ^ rv)) | (rv & ~(w[5] | ts | tl | w[1]));
    end
    if (w[11]) b = v;
    else a = v;
    return {sk, o, e, b, a};
  endfunction : ref_exec

  // ---------------------------------------------------------------
  // bus and instruction tasks
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dv, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {24'h0, ad};
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released at its own ready
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] r);
    araddr <= {24'h0, ad};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    dv = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic preload(input logic [15:0] a, input logic [15:0] b, input logic [1:0] f);
    logic [1:0] r;
    fetch_u.quiet();
    axi_wr({4'h0, RRX_REG_ACC_A}, {16'hA5A5, a}, r);
    `CHK(r, RRX_RESP_OKAY);
    axi_wr({4'h0, RRX_REG_ACC_B}, {16'h5A5A, b}, r);
    axi_wr({4'h0, RRX_REG_FLAGS}, {30'h0, f}, r);
    exp_a = a;
    exp_b = b;
    {exp_o, exp_e} = f;
  endtask : preload

  task automatic run(input logic [15:0] w, input int gap);
    logic [14:0] pc;
    logic [34:0] r;
    fetch_u.issue(w, gap, pc);
    r = ref_exec(w, exp_a, exp_b, exp_e, exp_o);
    {exp_skip, exp_o, exp_e, exp_b, exp_a} = r;
    expq.push_back({pc + (r[34] ? RRX_PC_SKIP : RRX_PC_STEP), r});
  endtask : run

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // result monitor and watchdog
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && done_q === 1'b1) begin
      `CHK(expq.size() > 0, 1'b1);
      q = expq.pop_front();
      `CHK(acc_a_q, q[15:0]);
      `CHK(acc_b_q, q[31:16]);
      `CHK(extend_q, q[32]);
      `CHK(overflow_q, q[33]);
      `CHK(skip_q, q[34]);
      `CHK(pc_next_q, q[49:35]);
    end
  end

  // whole run needs about 10000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h6c57ef5c;
    aresetn = 1'b0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({acc_a_q, acc_b_q, extend_q, overflow_q, done_q}, 35'h0);
    `CHK(instr_ready_q, 1'b1);
    axi_rd({4'h0, RRX_REG_CTRL}, d, rs);
    `CHK(d, {31'h0, RRX_CTL_EN_RST});
    {exp_a, exp_b, exp_e, exp_o, exp_skip} = '0;
    run(16'h0000, 0);
    // every low twelve-bit pattern of both groups, on corner operands with random flags
    for (i = 0; i < 4096; i++) begin
      if (i % 16 == 0) preload(corner[(i / 16) % 8], corner[7 - (i / 16) % 8], 2'($random(seed)));
      run({4'h0, 12'(i)}, $random(seed) & 1);
    end
    for (i = 0; i < 300; i++) begin
      if (i % 25 == 0) preload(16'($random(seed)), 16'($random(seed)), 2'($random(seed)));
      run(16'($random(seed)), $random(seed) & 3);
    end
    preload(16'h7FFF, 16'hFFFF, 2'b00);
    run(16'h0404, 0);
    run(16'h0C04, 0);
    fetch_u.quiet();
    // execute enable off: a held word must not run until it is set again
    axi_wr({4'h0, RRX_REG_CTRL}, 32'h0, rs);
    fetch_u.issue(16'h0500, 0, pc_hold);
    repeat (4) @(posedge aclk);
    fetch_u.quiet();
    `CHK(acc_a_q, exp_a);
    axi_wr({4'h0, RRX_REG_CTRL}, 32'h1, rs);
    run(16'h0500, 0);
    fetch_u.quiet();
    axi_wr(8'h10, 32'h0000_1234, rs);
    `CHK(rs, RRX_RESP_SLVERR);
    axi_rd(8'h02, d, rs);
    `CHK({rs, d}, {RRX_RESP_SLVERR, 32'h0});
    axi_rd({4'h0, RRX_REG_ACC_A}, d, rs);
    `CHK(d, {16'h0, exp_a});
    // low lane only: the high byte of B must survive
    wstrb <= 4'h1;
    axi_wr({4'h0, RRX_REG_ACC_B}, 32'h0000_BE3C, rs);
    wstrb <= 4'hF;
    exp_b[7:0] = 8'h3C;
    axi_rd({4'h0, RRX_REG_ACC_B}, d, rs);
    `CHK(d, {16'h0, exp_b});
    axi_rd({4'h0, RRX_REG_FLAGS}, d, rs);
    `CHK(d, {29'h0, exp_skip, exp_o, exp_e});
    `CHK(expq.size(), 0);
    finish_test();
  end
endmodule : tb_top
